//--- rtl/scc_pkg.sv
package scc_pkg;
  // Register numbers carried in the primary register field
  localparam logic [3:0] REG_IDENTIFICATION   = 4'h0;
  localparam logic [3:0] REG_SYSTEM_CONTROL   = 4'h1;
  localparam logic [3:0] REG_TRANSLATION_BASE = 4'h2;
  localparam logic [3:0] REG_DOMAIN_ACCESS    = 4'h3;
  localparam logic [3:0] REG_FAULT_STATUS     = 4'h5;
  localparam logic [3:0] REG_FAULT_ADDRESS    = 4'h6;
  localparam logic [3:0] REG_CACHE_OPERATIONS = 4'h7;
  localparam logic [3:0] REG_TLB_OPERATIONS   = 4'h8;
  localparam logic [3:0] REG_PROCESS_ID       = 4'hd;
  // Control register bit positions
  localparam int CTL_MMU_EN      = 0;
  localparam int CTL_ALIGN_EN    = 1;
  localparam int CTL_CACHE_EN    = 2;
  localparam int CTL_WBUF_EN     = 3;
  localparam int CTL_BIG_ENDIAN  = 7;
  localparam int CTL_SYS_PROT    = 8;
  localparam int CTL_ROM_PROT    = 9;
  localparam int CTL_HIGH_VECTOR = 13;
  // Writable control bits and the bits that always read one
  localparam logic [31:0] CTL_WRITE_MASK = 32'h0000_238f;
  localparam logic [31:0] CTL_ONES       = 32'h0000_0070;
  // Stored field masks of the other registers
  localparam logic [31:0] TTB_MASK = 32'hffff_c000;
  localparam logic [31:0] FSR_MASK = 32'h0000_00ff;
  localparam logic [31:0] PID_MASK = 32'hfe00_0000;
  // Operation selectors for registers 7 and 8
  localparam logic [3:0] SEL_CACHE_ALL   = 4'h7;
  localparam logic [2:0] OP2_INV_ALL     = 3'h0;
  localparam logic [2:0] OP2_INV_SINGLE  = 3'h1;
  localparam logic [3:0] SEL_TLB_LO      = 4'h5;
  localparam logic [3:0] SEL_TLB_HI      = 4'h7;
  // Vector bases
  localparam logic [31:0] VEC_BASE_HIGH = 32'hffff_0000;
  localparam logic [31:0] VEC_BASE_LOW  = 32'h0000_0000;
  // Instruction kinds issued to the coprocessor
  typedef enum logic [2:0] {
    KIND_REG_READ, KIND_REG_WRITE, KIND_DATA_OP, KIND_LOAD, KIND_STORE
  } scc_kind_type;
  // Host command register addresses
  localparam logic [3:0] HOST_ADDR_CMD    = 4'h0;
  localparam logic [3:0] HOST_ADDR_WDATA  = 4'h1;
  localparam logic [3:0] HOST_ADDR_STATUS = 4'h2;
  localparam logic [3:0] HOST_ADDR_RDATA  = 4'h3;
  // Command register field positions
  localparam int CMD_PRIMARY = 0;
  localparam int CMD_SECOND  = 4;
  localparam int CMD_OP2     = 8;
  localparam int CMD_OP1     = 11;
  localparam int CMD_KIND    = 14;
  localparam int CMD_PRIV    = 17;
endpackage : scc_pkg

//--- rtl/scc_if.sv
`timescale 1ns/10ps
`default_nettype none
// Coprocessor transfer link between the core and the control coprocessor
interface scc_if;
  logic                 req;
  scc_pkg::scc_kind_type kind;
  logic                 privileged;
  logic [2:0]           op1;
  logic [3:0]           primary_reg_field;
  logic [3:0]           secondary_reg_field;
  logic [2:0]           op2;
  logic [31:0]          wdata;
  logic                 done;
  logic                 undef_trap;
  logic [31:0]          rdata;
  modport core (output req, kind, privileged, op1, primary_reg_field,
                secondary_reg_field, op2, wdata, input done, undef_trap, rdata);
  modport coproc (input req, kind, privileged, op1, primary_reg_field,
                  secondary_reg_field, op2, wdata, output done, undef_trap, rdata);
endinterface : scc_if
`default_nettype wire

//--- rtl/scc_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Classifies one transfer: trap, valid access, and register-7/8 operations
module scc_decode
(
  // Transfer fields
  input  wire scc_pkg::scc_kind_type kind,
  input  wire logic                  privileged,
  input  wire logic [3:0]            primary,
  input  wire logic [3:0]            secondary,
  input  wire logic [2:0]            op2,
  // Classification
  output logic                       trap,
  output logic                       rd_ok,
  output logic                       wr_ok,
  output logic                       cache_inv,
  output logic                       tlb_inv_all,
  output logic                       tlb_inv_one
);
  logic is_rd;
  logic is_wr;
  logic tlb_sel;

  // Only register transfers from a privileged mode pass
  always_comb
  begin
    is_rd   = (kind == scc_pkg::KIND_REG_READ);
    is_wr   = (kind == scc_pkg::KIND_REG_WRITE);
    trap    = !(is_rd || is_wr) || !privileged;
    tlb_sel = (secondary >= scc_pkg::SEL_TLB_LO) && (secondary <= scc_pkg::SEL_TLB_HI);
    rd_ok   = 1'b0;
    wr_ok   = 1'b0;
    // Primary field picks the register; invalid ones do nothing, no trap
    case (primary)
      scc_pkg::REG_IDENTIFICATION: rd_ok = is_rd && !trap;
      scc_pkg::REG_SYSTEM_CONTROL, scc_pkg::REG_TRANSLATION_BASE,
      scc_pkg::REG_DOMAIN_ACCESS, scc_pkg::REG_FAULT_STATUS,
      scc_pkg::REG_FAULT_ADDRESS, scc_pkg::REG_PROCESS_ID:
      begin
        rd_ok = is_rd && !trap;
        wr_ok = is_wr && !trap;
      end
      scc_pkg::REG_CACHE_OPERATIONS, scc_pkg::REG_TLB_OPERATIONS:
        wr_ok = is_wr && !trap;
      default: ;
    endcase
    // Secondary field and second opcode select the action
    cache_inv   = wr_ok && (primary == scc_pkg::REG_CACHE_OPERATIONS) &&
                  (secondary == scc_pkg::SEL_CACHE_ALL) && (op2 == scc_pkg::OP2_INV_ALL);
    tlb_inv_all = wr_ok && (primary == scc_pkg::REG_TLB_OPERATIONS) && tlb_sel &&
                  (op2 == scc_pkg::OP2_INV_ALL);
    tlb_inv_one = wr_ok && (primary == scc_pkg::REG_TLB_OPERATIONS) && tlb_sel &&
                  (op2 == scc_pkg::OP2_INV_SINGLE);
  end
endmodule : scc_decode
`default_nettype wire

//--- rtl/scc_coproc.sv
// Summary of operation
// - Registers reached only by privileged register transfers
// - Data, load, store or user transfers trap
// - Primary field picks register; others pick action
// - Software zeroes opcode fields except registers 7,8,13; issuer passes them on
// - Invalid register: no access and no trap
// - Per-register read and write permissions apply
// - Register 0 returns fixed identification word
// - Software never writes register 0
// - Reset clears control bits except vector bit
// - Vector bit loaded from strap during reset
// - Bits 0,2,3 enable MMU, cache, buffer
// - Bit 1 enables alignment fault checking
// - Bits 4-6 read one, writes ignored
// - Bit 7 selects big-endian byte order
// - Bits 8,9 stored and passed to MMU
// - Unpredictable control bits; software writes zero
// - Software changes control by read-modify-write
// - Software writes zero to reserved bits
// - Vector bit selects high or low base
`timescale 1ns/10ps
`default_nettype none
module scc_coproc
#(
  parameter logic [31:0] ID_WORD = 32'h1234_5001 // Arbitrary value; low nibble is revision
)
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // Core link
  scc_if.coproc      cp,
  // Strap
  input  wire logic  high_vector_strap,
  // Configuration outputs
  output logic       mmu_enable,
  output logic       align_check,
  output logic       unified_cache_enable,
  output logic       write_buffer_enable,
  output logic       big_endian,
  output logic       system_protect,
  output logic       rom_protect,
  output logic [31:0] vector_base,
  output logic [31:0] translation_table_base,
  output logic [31:0] domain_access_control,
  output logic [31:0] fault_status,
  output logic [31:0] fault_address,
  output logic [6:0]  relocation_process_id,
  // Maintenance pulses
  output logic       cache_invalidate,
  output logic       tlb_invalidate_all,
  output logic       tlb_invalidate_single,
  output logic [31:0] tlb_invalidate_addr
);
  // Whole state of the coprocessor in one register
  typedef struct packed {
    // Software-visible registers
    logic [31:0] ctl;
    logic [31:0] ttb;
    logic [31:0] dac;
    logic [31:0] fsr;
    logic [31:0] far;
    logic [31:0] pid;
    logic [31:0] vbase;
    // Link answer
    logic        done;
    logic        trap;
    logic [31:0] rdata;
    // Maintenance strobes
    logic        cinv;
    logic        tinv_all;
    logic        tinv_one;
    logic [31:0] tinv_addr;
  } scc_state_type;

  scc_state_type st;
  scc_state_type next_st;
  // Classification of the transfer on the link this cycle
  logic trap;
  logic rd_ok;
  logic wr_ok;
  logic cache_inv;
  logic tlb_inv_all;
  logic tlb_inv_one;

  // Decoder is kept apart so the trap and permission rules live in one place
  scc_decode u_decode
  (
    .kind        (cp.kind),
    .privileged  (cp.privileged),
    .primary     (cp.primary_reg_field),
    .secondary   (cp.secondary_reg_field),
    .op2         (cp.op2),
    .trap        (trap),
    .rd_ok       (rd_ok),
    .wr_ok       (wr_ok),
    .cache_inv   (cache_inv),
    .tlb_inv_all (tlb_inv_all),
    .tlb_inv_one (tlb_inv_one)
  );

  // Next state: reset, register writes, read mux and one-cycle answers
  always_comb
  begin
    next_st          = st;
    // Answer and pulse fields fall back to zero, so each lasts exactly one cycle
    next_st.done     = 1'b0;
    next_st.trap     = 1'b0;
    next_st.rdata    = 32'h0000_0000;
    next_st.cinv     = 1'b0;
    next_st.tinv_all = 1'b0;
    next_st.tinv_one = 1'b0;
    if (sys_rst)
    begin
      // Strap is caught by the clock while reset holds, so no port feeds an async reset
      next_st = '0;
      next_st.ctl[scc_pkg::CTL_HIGH_VECTOR] = high_vector_strap;
    end
    else if (cp.req)
    begin
      // Every request is answered on the next edge, trapped or not
      next_st.done = 1'b1;
      next_st.trap = trap;
      if (rd_ok)
      begin
        // Unused and unpredictable positions read as zero
        case (cp.primary_reg_field)
          scc_pkg::REG_IDENTIFICATION:   next_st.rdata = ID_WORD;
          scc_pkg::REG_SYSTEM_CONTROL:   next_st.rdata = st.ctl | scc_pkg::CTL_ONES;
          scc_pkg::REG_TRANSLATION_BASE: next_st.rdata = st.ttb;
          scc_pkg::REG_DOMAIN_ACCESS:    next_st.rdata = st.dac;
          scc_pkg::REG_FAULT_STATUS:     next_st.rdata = st.fsr;
          scc_pkg::REG_FAULT_ADDRESS:    next_st.rdata = st.far;
          scc_pkg::REG_PROCESS_ID:       next_st.rdata = st.pid;
          default:                       next_st.rdata = 32'h0000_0000;
        endcase
      end
      // Reserved and read-only registers never reach this case
      if (wr_ok)
      begin
        case (cp.primary_reg_field)
          // Only defined control bits store; fixed-one and unpredictable ones drop
          scc_pkg::REG_SYSTEM_CONTROL:   next_st.ctl = cp.wdata & scc_pkg::CTL_WRITE_MASK;
          // Translation base keeps only the table pointer bits
          scc_pkg::REG_TRANSLATION_BASE: next_st.ttb = cp.wdata & scc_pkg::TTB_MASK;
          // Domain access and fault address store every bit
          scc_pkg::REG_DOMAIN_ACCESS:    next_st.dac = cp.wdata;
          // Fault status keeps domain and type; bit 8 always reads zero
          scc_pkg::REG_FAULT_STATUS:     next_st.fsr = cp.wdata & scc_pkg::FSR_MASK;
          scc_pkg::REG_FAULT_ADDRESS:    next_st.far = cp.wdata;
          // Process identifier keeps the seven relocation bits
          scc_pkg::REG_PROCESS_ID:       next_st.pid = cp.wdata & scc_pkg::PID_MASK;
          default: ;
        endcase
      end
      // Maintenance strobes carry the written address for a single-entry flush
      next_st.cinv     = cache_inv;
      next_st.tinv_all = tlb_inv_all;
      next_st.tinv_one = tlb_inv_one;
      if (tlb_inv_one)
        next_st.tinv_addr = cp.wdata;
    end

    // Vector base follows the control bit on the same edge, so the output comes
    // straight from a flop and shows no decode delay after a control write
    next_st.vbase = next_st.ctl[scc_pkg::CTL_HIGH_VECTOR] ?
                    scc_pkg::VEC_BASE_HIGH : scc_pkg::VEC_BASE_LOW;
  end

  // Single state register
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  // Link answers; the issuer only looks at them while done is high
  assign cp.done       = st.done;
  assign cp.undef_trap = st.trap;
  assign cp.rdata      = st.rdata;

  // Memory system enables, taken straight from the stored control bits
  assign mmu_enable             = st.ctl[scc_pkg::CTL_MMU_EN];
  assign unified_cache_enable   = st.ctl[scc_pkg::CTL_CACHE_EN];
  assign write_buffer_enable    = st.ctl[scc_pkg::CTL_WBUF_EN];
  assign align_check            = st.ctl[scc_pkg::CTL_ALIGN_EN];

  // Byte order and the protection modifiers handed on to the MMU
  assign big_endian             = st.ctl[scc_pkg::CTL_BIG_ENDIAN];
  assign system_protect         = st.ctl[scc_pkg::CTL_SYS_PROT];
  assign rom_protect            = st.ctl[scc_pkg::CTL_ROM_PROT];

  // Vector base, registered together with its control bit
  assign vector_base            = st.vbase;

  // Register copies for the translation hardware
  assign translation_table_base = st.ttb;
  assign domain_access_control  = st.dac;
  assign fault_status           = st.fsr;
  assign fault_address          = st.far;
  assign relocation_process_id  = st.pid[31:25];

  // Maintenance pulses stand only in the cycle after their request
  assign cache_invalidate       = st.cinv;
  assign tlb_invalidate_all     = st.tinv_all;
  assign tlb_invalidate_single  = st.tinv_one;
  assign tlb_invalidate_addr    = st.tinv_addr;
endmodule : scc_coproc
`default_nettype wire

//--- rtl/scc_core.sv
`timescale 1ns/10ps
`default_nettype none
// Core-side issuer: software command registers turn into one link transfer
module scc_core
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // Core link
  scc_if.core              cp
);
  typedef enum logic [0:0] {ST_IDLE, ST_WAIT} scc_phase_type;
  typedef struct packed {
    scc_phase_type         phase;
    logic                  req;
    scc_pkg::scc_kind_type kind;
    logic                  priv;
    logic [2:0]            op1;
    logic [3:0]            prim;
    logic [3:0]            sec;
    logic [2:0]            op2;
    logic [31:0]           wd;
    logic [31:0]           result;
    logic                  trapped;
    logic                  complete;
    logic [31:0]           rdata;
  } scc_host_type;

  scc_host_type st;
  scc_host_type next_st;

  // Command decode, link sequencing and read mux
  always_comb
  begin
    next_st       = st;
    next_st.req   = 1'b0;
    next_st.rdata = 32'h0000_0000;
    if (sys_rst)
      next_st = '0;
    else
    begin
      case (st.phase)
        ST_IDLE:
          if (wr && addr == scc_pkg::HOST_ADDR_CMD)
          begin
            // Fields go out as software wrote them; zeroing unused ones is its job
            next_st.prim     = wdata[scc_pkg::CMD_PRIMARY +: 4];
            next_st.sec      = wdata[scc_pkg::CMD_SECOND +: 4];
            next_st.op2      = wdata[scc_pkg::CMD_OP2 +: 3];
            next_st.op1      = wdata[scc_pkg::CMD_OP1 +: 3];
            next_st.kind     = scc_pkg::scc_kind_type'(wdata[scc_pkg::CMD_KIND +: 3]);
            next_st.priv     = wdata[scc_pkg::CMD_PRIV];
            next_st.req      = 1'b1;
            next_st.complete = 1'b0;
            next_st.phase    = ST_WAIT;
          end
        ST_WAIT:
          if (cp.done)
          begin
            next_st.result   = cp.rdata;
            next_st.trapped  = cp.undef_trap;
            next_st.complete = 1'b1;
            next_st.phase    = ST_IDLE;
          end
        default: next_st.phase = ST_IDLE;
      endcase
      // Write data for the next transfer; writes while a transfer is busy are dropped
      if (wr && addr == scc_pkg::HOST_ADDR_WDATA && st.phase == ST_IDLE)
        next_st.wd = wdata;
      if (rd)
      begin
        if (addr == scc_pkg::HOST_ADDR_STATUS)
          next_st.rdata = {29'h0, st.trapped, st.complete, st.phase == ST_WAIT};
        else if (addr == scc_pkg::HOST_ADDR_RDATA)
          next_st.rdata = st.result;
        else if (addr == scc_pkg::HOST_ADDR_WDATA)
          next_st.rdata = st.wd;
        else
          next_st.rdata = 32'h0000_0000;
      end
    end
  end

  // Single state register
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  assign rdata                  = st.rdata;
  assign cp.req                 = st.req;
  assign cp.kind                = st.kind;
  assign cp.privileged          = st.priv;
  assign cp.op1                 = st.op1;
  assign cp.primary_reg_field   = st.prim;
  assign cp.secondary_reg_field = st.sec;
  assign cp.op2                 = st.op2;
  assign cp.wdata               = st.wd;
endmodule : scc_core
`default_nettype wire

//--- dv/scc_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Link checks between the issuer and the coprocessor
module scc_asserts
#(
  parameter logic [31:0] ID_WORD = 32'h1234_5001 // Arbitrary value
)
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // Link signals
  input wire logic                  req,
  input wire scc_pkg::scc_kind_type kind,
  input wire logic                  privileged,
  input wire logic [3:0]            primary_reg_field,
  input wire logic                  done,
  input wire logic                  undef_trap,
  input wire logic [31:0]           rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // A legal transfer is a privileged register read or write
  logic xfer;
  logic rdx;
  assign xfer = req && privileged &&
                (kind inside {scc_pkg::KIND_REG_READ, scc_pkg::KIND_REG_WRITE});
  assign rdx  = xfer && (kind == scc_pkg::KIND_REG_READ);

  AST_DONE_NEXT: assert property (req |=> done)
    else $error("no answer one cycle after a request");
  AST_DONE_CAUSE: assert property (done |-> $past(req))
    else $error("answer without a request");
  AST_TRAP_BAD: assert property (req && !xfer |=> done && undef_trap)
    else $error("disallowed transfer not trapped");
  AST_NO_TRAP: assert property (xfer |=> !undef_trap)
    else $error("legal transfer trapped");
  AST_ID_WORD: assert property (rdx && primary_reg_field == 4'h0 |=> rdata == ID_WORD)
    else $error("identification word wrong");
  AST_CTL_READ: assert property (rdx && primary_reg_field == 4'h1 |=>
      rdata[6:4] == 3'h7 && rdata[12:10] == 3'h0 && rdata[31:14] == 18'h0)
    else $error("control read fixed bits wrong");
  AST_RSV_READ: assert property (rdx && (primary_reg_field inside
      {4'h4, 4'h7, 4'h8, [4'h9:4'hc], 4'he, 4'hf}) |=> rdata == 32'h0)
    else $error("reserved read not zero");
  AST_TRAP_ZERO: assert property (undef_trap |-> done && rdata == 32'h0)
    else $error("trap answer carries data");
  AST_WRITE_ZERO: assert property (req && kind == scc_pkg::KIND_REG_WRITE |=>
      rdata == 32'h0)
    else $error("write answer carries data");
  AST_RDATA_IDLE: assert property (!done |-> rdata == 32'h0)
    else $error("read data stands outside an answer");
endmodule : scc_asserts
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [31:0] ID_VAL = 32'h1234_5001; // Arbitrary value
  localparam scc_pkg::scc_kind_type RD = scc_pkg::KIND_REG_READ;
  localparam scc_pkg::scc_kind_type WR = scc_pkg::KIND_REG_WRITE;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        strap = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, vbase, taddr, q;
  logic [31:0] ttb, dac, fsr, fadr;
  logic        mmu, aln, cen, wbe, big, sysp, romp, cinv, tall, tone;
  logic [6:0]  pid;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          ncinv = 0;
  int          ntall = 0;
  int          ntone = 0;
  logic [31:0] pat [4] = '{32'hffff_ffff, 32'h0000_0285, 32'h0000_214a, 32'h0};
  logic [3:0]  rwr [5] = '{4'h2, 4'h3, 4'h5, 4'h6, 4'hd};
  logic [31:0] rwe [5] = '{32'hffff_c000, 32'hffff_ffff, 32'hff, 32'hffff_ffff, 32'hfe00_0000};
  // Register 0 stays out of the reserved writes: its write effect is undefined
  logic [3:0]  rsv [8] = '{4'ha, 4'h4, 4'h7, 4'h8, 4'h9, 4'hc, 4'he, 4'hf};
  scc_pkg::scc_kind_type bad [3] = '{scc_pkg::KIND_DATA_OP, scc_pkg::KIND_LOAD,
                                     scc_pkg::KIND_STORE};

  always #25 clk = ~clk;

  scc_if scc_if_inst ();
  scc_core scc_core_inst (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cp(scc_if_inst.core));
  scc_coproc #(.ID_WORD(ID_VAL)) scc_coproc_inst (.clk(clk), .sys_rst(sys_rst),
    .cp(scc_if_inst.coproc), .high_vector_strap(strap), .mmu_enable(mmu),
    .align_check(aln), .unified_cache_enable(cen), .write_buffer_enable(wbe),
    .big_endian(big), .system_protect(sysp), .rom_protect(romp), .vector_base(vbase),
    .translation_table_base(ttb), .domain_access_control(dac), .fault_status(fsr),
    .fault_address(fadr), .relocation_process_id(pid), .cache_invalidate(cinv),
    .tlb_invalidate_all(tall), .tlb_invalidate_single(tone), .tlb_invalidate_addr(taddr));
  scc_asserts #(.ID_WORD(ID_VAL)) scc_asserts_inst (.clk(clk), .sys_rst(sys_rst),
    .req(scc_if_inst.req), .kind(scc_if_inst.kind), .privileged(scc_if_inst.privileged),
    .primary_reg_field(scc_if_inst.primary_reg_field), .done(scc_if_inst.done),
    .undef_trap(scc_if_inst.undef_trap), .rdata(scc_if_inst.rdata));

  // Maintenance pulses last one cycle, so they are counted here
  always @(posedge clk)
  begin
    if (cinv === 1'b1)
      ncinv++;
    if (tall === 1'b1)
      ntall++;
    if (tone === 1'b1)
      ntone++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One software port cycle; read data is taken in the cycle after the strobe
  task automatic sw(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask : sw

  // Full transfer: operand, command, bounded status poll, result
  task automatic acc(input scc_pkg::scc_kind_type k, input logic p, input logic [3:0] r,
                     input logic [3:0] s, input logic [2:0] o2, input logic [31:0] d,
                     input logic t, input logic [31:0] e);
    sw(1'b1, scc_pkg::HOST_ADDR_WDATA, d);
    sw(1'b1, scc_pkg::HOST_ADDR_CMD, {14'h0, p, k, 3'h0, o2, s, r});
    q = 32'h1;
    for (int i = 0; i < 20 && q[0] !== 1'b0; i++)
      sw(1'b0, scc_pkg::HOST_ADDR_STATUS, 32'h0);
    chk(q, {29'h0, t, 2'b10});
    sw(1'b0, scc_pkg::HOST_ADDR_RDATA, 32'h0);
    chk(q, e);
  endtask : acc

  // Strap flips after release; the vector bit must keep the value seen in reset
  task automatic rst(input logic v);
    sys_rst <= 1'b1;
    strap <= v;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    strap <= ~v;
    #1;
  endtask : rst

  task automatic test_done();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    rst(1'b1);
    chk(vbase, 32'hffff_0000);
    acc(RD, 1'b1, 4'h1, 4'h0, 3'h0, 32'h0, 1'b0, 32'h0000_2070);
    acc(RD, 1'b1, 4'h0, 4'h0, 3'h0, 32'h0, 1'b0, ID_VAL);
    foreach (pat[i])
    begin
      acc(WR, 1'b1, 4'h1, 4'h0, 3'h0, pat[i], 1'b0, 32'h0);
      acc(RD, 1'b1, 4'h1, 4'h0, 3'h0, 32'h0, 1'b0, (pat[i] & 32'h238f) | 32'h70);
      chk({28'h0, wbe, cen, aln, mmu}, {28'h0, pat[i][3:0]});
      chk({29'h0, romp, sysp, big}, {29'h0, pat[i][9:7]});
      chk(vbase, pat[i][13] ? 32'hffff_0000 : 32'h0);
    end
    // Read-modify-write sets byte order and MMU bits and keeps the rest
    acc(RD, 1'b1, 4'h1, 4'h0, 3'h0, 32'h0, 1'b0, 32'h70);
    acc(WR, 1'b1, 4'h1, 4'h0, 3'h0, q | 32'h81, 1'b0, 32'h0);
    acc(RD, 1'b1, 4'h1, 4'h0, 3'h0, 32'h0, 1'b0, 32'hf1);
    chk({30'h0, big, mmu}, 32'h3);
    foreach (rwr[i])
    begin
      acc(WR, 1'b1, rwr[i], 4'h0, 3'h0, 32'hffff_ffff, 1'b0, 32'h0);
      acc(RD, 1'b1, rwr[i], 4'h0, 3'h0, 32'h0, 1'b0, rwe[i]);
    end
    chk({25'h0, pid}, 32'h7f);
    chk(ttb, 32'hffff_c000);
    chk(dac, 32'hffff_ffff);
    chk(fsr, 32'h0000_00ff);
    chk(fadr, 32'hffff_ffff);
    foreach (rsv[i])
    begin
      acc(WR, 1'b1, rsv[i], 4'h0, 3'h0, 32'hffff_ffff, 1'b0, 32'h0);
      acc(RD, 1'b1, rsv[i], 4'h0, 3'h0, 32'h0, 1'b0, 32'h0);
    end
    foreach (bad[i])
      acc(bad[i], 1'b1, 4'h3, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    acc(WR, 1'b0, 4'h3, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    acc(RD, 1'b0, 4'h3, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
    acc(RD, 1'b1, 4'h3, 4'h0, 3'h0, 32'h0, 1'b0, 32'hffff_ffff);
    acc(WR, 1'b1, 4'h7, 4'h7, 3'h0, 32'h0, 1'b0, 32'h0);
    for (int s = 5; s < 8; s++)
      acc(WR, 1'b1, 4'h8, 4'(s), 3'h0, 32'h0, 1'b0, 32'h0);
    acc(WR, 1'b1, 4'h8, 4'h7, 3'h1, 32'h0001_2000, 1'b0, 32'h0);
    chk(32'(ncinv), 32'h1);
    chk(32'(ntall), 32'h3);
    chk(32'(ntone), 32'h1);
    chk(taddr, 32'h0001_2000);
    @(posedge clk);
    rst(1'b0);
    chk(vbase, 32'h0);
    chk(ttb | dac | fsr | fadr, 32'h0);
    chk({25'h0, pid}, 32'h0);
    acc(RD, 1'b1, 4'h1, 4'h0, 3'h0, 32'h0, 1'b0, 32'h70);
    acc(RD, 1'b1, 4'hd, 4'h0, 3'h0, 32'h0, 1'b0, 32'h0);
    sw(1'b0, 4'h5, 32'h0);
    chk(q, 32'h0);
    test_done();
  end

  // Watchdog: the sequence needs about 530 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
